// ===== hw/pcs_autoneg_mgmt_regs.sv
// Next page receive, extended status, interrupt and loopback registers with their MDIO slave.
`include "pcs_autoneg_mgmt_regs.svh"
`default_nettype none
// Function
// RULE_01: Next page receive bit 15 is read-only: 1 more pages follow, 0 last page.
// RULE_02: Next page receive bit 14 is a read-only acknowledge set on page reception.
// RULE_03: Bits 10:0 hold the received code, reset zero; bit 13 selects its meaning.
// RULE_04: Next page receive bit 12 is read-only: partner can comply with message.
// RULE_05: Next page receive bit 11 is a read-only toggle, resets to zero.
// RULE_06: Extended status bit 15 always reads 1; writes do nothing.
// RULE_07: Extended status bits 14 to 0 always read zero.
// RULE_08: With interrupt enabled, status bit 1 sets on each auto-negotiation completion.
// RULE_09: The status bit stays set until the station writes 0 to it.
// RULE_10: With interrupt disabled the status bit is forced to 0; it resets to 0.
// RULE_11: Interrupt control bit 0 is a read/write enable resetting to 1; upper bits zero.
// RULE_12: Loopback position bit 0 is read/write, reset 0: 0 before, 1 inside transceiver.
// RULE_13: The position bit only picks the place; loopback on/off comes from outside.
// RULE_14: While loopback is active a continuous Idle stream goes to the transceiver.
// RULE_15: Registers sit at MDIO addresses 8, 15, 16, 17, valid only in serial PHY mode.
// RULE_16: Writes to read-only, constant or reserved bits are ignored.
module pcs_autoneg_mgmt_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOeN,
  input wire logic [4:0] phyAddr,
  input wire logic sgmiiMode,
  input wire logic pageRxValid,
  input wire logic pageRxNext,
  input wire logic pageRxAck,
  input wire logic pageRxMsg,
  input wire logic pageRxAck2,
  input wire logic pageRxToggle,
  input wire logic [10:0] pageRxCode,
  input wire logic anComplete,
  input wire logic loopbackEn,
  output logic loopbackPosition,
  output logic anIntrStatus,
  input wire logic [7:0] txDataIn,
  input wire logic txIsKIn,
  output logic [7:0] txData,
  output logic txIsK,
  output logic [7:0] rxLoopData,
  output logic rxLoopIsK,
  output logic xcvrLoopback
);
  logic [1:0] pinSync;
  logic mdcS;
  logic mdioS;
  logic mdcPrev_r;
  logic mdcPrev_nxt;
  logic mdcRise;

  pcs_autoneg_mgmt_pkg::mdio_state_t state_r;
  pcs_autoneg_mgmt_pkg::mdio_state_t state_nxt;
  logic [4:0] bitCnt_r;
  logic [4:0] bitCnt_nxt;
  logic seenOne_r;
  logic seenOne_nxt;
  logic [10:0] hdr_r;
  logic [10:0] hdr_nxt;
  logic [11:0] hdrFull;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [4:0] regAddr_r;
  logic [4:0] regAddr_nxt;
  logic mdioOut_nxt;
  logic mdioOeN_nxt;
  logic wrValid_r;
  logic wrValid_nxt;
  logic [4:0] wrAddr_r;
  logic [4:0] wrAddr_nxt;
  logic [15:0] wrData_r;
  logic [15:0] wrData_nxt;

  pcs_autoneg_mgmt_pkg::reg_word_t npRx_r;
  pcs_autoneg_mgmt_pkg::reg_word_t npRx_nxt;
  logic intrEn_r;
  logic intrEn_nxt;
  logic intrStat_r;
  logic intrStat_nxt;
  logic loopPos_r;
  logic loopPos_nxt;

  loop_ctl_if loopCtl ();

  pin_sync #(
    .W(2)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .din({mdc, mdioIn}),
    .dout(pinSync)
  );

  assign mdcS = pinSync[1];
  assign mdioS = pinSync[0];

  // Read view of the four registers; other addresses of this PHY read as zero.
  function automatic pcs_autoneg_mgmt_pkg::reg_word_t readValue(
    input logic [4:0] addr,
    input pcs_autoneg_mgmt_pkg::reg_word_t npRx,
    input logic en,
    input logic stat,
    input logic pos
  );
    pcs_autoneg_mgmt_pkg::reg_word_t v;
    v = 16'h0000;
    case (addr)
      `REG_NP_RX: begin
        v = npRx; // RULE_15
      end
      `REG_EXT_STATUS: begin
        v = `EXT_STATUS_VALUE; // RULE_06 RULE_07
      end
      `REG_AN_INTR: begin
        v[`INTR_EN_BIT] = en; // RULE_11
        v[`INTR_STAT_BIT] = stat;
      end
      `REG_LOOP_POS: begin
        v[`LOOP_POS_BIT] = pos; // RULE_12
      end
      default: begin
        v = 16'h0000;
      end
    endcase
    return v;
  endfunction : readValue

  assign mdcRise = mdcS && !mdcPrev_r;
  assign hdrFull = {hdr_r, mdioS};

  // MDIO frame decoder, stepping once per rising edge of the management clock.
  always_comb begin
    mdcPrev_nxt = mdcS;
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    seenOne_nxt = seenOne_r;
    hdr_nxt = hdr_r;
    shift_nxt = shift_r;
    regAddr_nxt = regAddr_r;
    mdioOut_nxt = mdioOut;
    mdioOeN_nxt = mdioOeN;
    wrValid_nxt = 1'b0;
    wrAddr_nxt = wrAddr_r;
    wrData_nxt = wrData_r;
    if (mdcRise) begin
      bitCnt_nxt = bitCnt_r + `MDIO_CNT_FIRST;
      case (state_r)
        pcs_autoneg_mgmt_pkg::MD_IDLE: begin
          mdioOeN_nxt = 1'b1;
          if (mdioS) begin
            seenOne_nxt = 1'b1;
          end else if (seenOne_r) begin
            seenOne_nxt = 1'b0;
            bitCnt_nxt = `MDIO_CNT_FIRST;
            state_nxt = pcs_autoneg_mgmt_pkg::MD_HEAD;
          end
        end
        pcs_autoneg_mgmt_pkg::MD_HEAD: begin
          hdr_nxt = hdrFull[10:0];
          if (bitCnt_r == `MDIO_CNT_ST1 && !mdioS) begin
            state_nxt = pcs_autoneg_mgmt_pkg::MD_IDLE;
          end else if (bitCnt_r == `MDIO_CNT_HDR_END) begin
            regAddr_nxt = hdrFull[4:0];
            if (!sgmiiMode || hdrFull[9:5] != phyAddr) begin
              state_nxt = pcs_autoneg_mgmt_pkg::MD_SKIP; // RULE_15
            end else if (hdrFull[11:10] == `MDIO_OP_READ) begin
              state_nxt = pcs_autoneg_mgmt_pkg::MD_READ;
              shift_nxt = readValue(hdrFull[4:0], npRx_r, intrEn_r, intrStat_r, loopPos_r);
            end else if (hdrFull[11:10] == `MDIO_OP_WRITE) begin
              state_nxt = pcs_autoneg_mgmt_pkg::MD_WRITE;
            end else begin
              state_nxt = pcs_autoneg_mgmt_pkg::MD_SKIP;
            end
          end
        end
        pcs_autoneg_mgmt_pkg::MD_READ: begin
          if (bitCnt_r == `MDIO_CNT_TA1) begin
            mdioOut_nxt = 1'b0;
            mdioOeN_nxt = 1'b0;
          end else if (bitCnt_r == `MDIO_CNT_LAST) begin
            mdioOeN_nxt = 1'b1;
            mdioOut_nxt = 1'b0;
            state_nxt = pcs_autoneg_mgmt_pkg::MD_IDLE;
          end else begin
            mdioOut_nxt = shift_r[15];
            shift_nxt = {shift_r[14:0], 1'b0};
          end
        end
        pcs_autoneg_mgmt_pkg::MD_WRITE: begin
          if (bitCnt_r > `MDIO_CNT_TA2) begin
            shift_nxt = {shift_r[14:0], mdioS};
          end
          if (bitCnt_r == `MDIO_CNT_LAST) begin
            wrValid_nxt = 1'b1;
            wrAddr_nxt = regAddr_r;
            wrData_nxt = {shift_r[14:0], mdioS};
            state_nxt = pcs_autoneg_mgmt_pkg::MD_IDLE;
          end
        end
        pcs_autoneg_mgmt_pkg::MD_SKIP: begin
          if (bitCnt_r == `MDIO_CNT_LAST) begin
            state_nxt = pcs_autoneg_mgmt_pkg::MD_IDLE;
          end
        end
        default: begin
          mdioOeN_nxt = 1'b1;
          state_nxt = pcs_autoneg_mgmt_pkg::MD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mdcPrev_r <= 1'b0;
      state_r <= pcs_autoneg_mgmt_pkg::MD_IDLE;
      bitCnt_r <= 5'h00;
      seenOne_r <= 1'b0;
      hdr_r <= 11'h000;
      shift_r <= 16'h0000;
      regAddr_r <= 5'h00;
      mdioOut <= 1'b0;
      mdioOeN <= 1'b1;
      wrValid_r <= 1'b0;
      wrAddr_r <= 5'h00;
      wrData_r <= 16'h0000;
    end else if (clkEn) begin
      mdcPrev_r <= mdcPrev_nxt;
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      seenOne_r <= seenOne_nxt;
      hdr_r <= hdr_nxt;
      shift_r <= shift_nxt;
      regAddr_r <= regAddr_nxt;
      mdioOut <= mdioOut_nxt;
      mdioOeN <= mdioOeN_nxt;
      wrValid_r <= wrValid_nxt;
      wrAddr_r <= wrAddr_nxt;
      wrData_r <= wrData_nxt;
    end
  end

  // Register contents; writes touch only the enable, status and position bits.
  always_comb begin
    npRx_nxt = npRx_r;
    if (pageRxValid) begin
      npRx_nxt[`NP_NEXT_BIT] = pageRxNext; // RULE_01
      npRx_nxt[`NP_ACK_BIT] = pageRxAck; // RULE_02
      npRx_nxt[`NP_MSG_BIT] = pageRxMsg; // RULE_03
      npRx_nxt[`NP_ACK2_BIT] = pageRxAck2; // RULE_04
      npRx_nxt[`NP_TOGGLE_BIT] = pageRxToggle; // RULE_05
      npRx_nxt[`NP_CODE_MSB:0] = pageRxCode; // RULE_03
    end

    intrEn_nxt = intrEn_r;
    loopPos_nxt = loopPos_r;
    intrStat_nxt = intrStat_r;
    if (wrValid_r && wrAddr_r == `REG_AN_INTR) begin
      intrEn_nxt = wrData_r[`INTR_EN_BIT]; // RULE_11
      if (!wrData_r[`INTR_STAT_BIT]) begin
        intrStat_nxt = 1'b0; // RULE_09
      end
    end
    if (wrValid_r && wrAddr_r == `REG_LOOP_POS) begin
      loopPos_nxt = wrData_r[`LOOP_POS_BIT]; // RULE_12 RULE_16
    end
    // A completion in the cycle of a clearing write that leaves the enable at 1 still sets the status bit.
    if (anComplete) begin
      intrStat_nxt = 1'b1; // RULE_08
    end
    if (!intrEn_nxt) begin
      intrStat_nxt = 1'b0; // RULE_10
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      npRx_r <= `NP_RX_RESET;
      intrEn_r <= `INTR_EN_RESET;
      intrStat_r <= `INTR_STAT_RESET;
      loopPos_r <= `LOOP_POS_RESET;
    end else if (clkEn) begin
      npRx_r <= npRx_nxt;
      intrEn_r <= intrEn_nxt;
      intrStat_r <= intrStat_nxt;
      loopPos_r <= loopPos_nxt;
    end
  end

  assign loopbackPosition = loopPos_r;
  assign anIntrStatus = intrStat_r;
  assign loopCtl.loopActive = loopbackEn; // RULE_13
  assign loopCtl.loopInXcvr = loopPos_r; // RULE_13

  idle_tx_gen u_idle_tx_gen (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .loop(loopCtl),
    .txDataIn(txDataIn),
    .txIsKIn(txIsKIn),
    .txData(txData),
    .txIsK(txIsK),
    .rxLoopData(rxLoopData),
    .rxLoopIsK(rxLoopIsK),
    .xcvrLoopback(xcvrLoopback)
  );
endmodule : pcs_autoneg_mgmt_regs
`default_nettype wire

// ===== common/pcs_autoneg_mgmt_regs.svh
// Register addresses, field positions, reset values and line codes of the management block.
`ifndef PCS_AUTONEG_MGMT_REGS_SVH
`define PCS_AUTONEG_MGMT_REGS_SVH

`define REG_NP_RX 5'h08
`define REG_EXT_STATUS 5'h0f
`define REG_AN_INTR 5'h10
`define REG_LOOP_POS 5'h11

`define NP_NEXT_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_BIT 13
`define NP_ACK2_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_CODE_MSB 10
`define NP_RX_RESET 16'h0000

`define EXT_STATUS_VALUE 16'h8000

`define INTR_EN_BIT 0
`define INTR_STAT_BIT 1
`define INTR_EN_RESET 1'b1
`define INTR_STAT_RESET 1'b0
`define LOOP_POS_BIT 0
`define LOOP_POS_RESET 1'b0

`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_CNT_FIRST 5'h01
`define MDIO_CNT_ST1 5'h01
`define MDIO_CNT_HDR_END 5'h0d
`define MDIO_CNT_TA1 5'h0e
`define MDIO_CNT_TA2 5'h0f
`define MDIO_CNT_LAST 5'h1f

`define CODE_K28_5 8'hbc
`define CODE_D16_2 8'h50

`endif

// ===== common/pcs_autoneg_mgmt_pkg.sv
// Types shared by the management register block.
`default_nettype none
package pcs_autoneg_mgmt_pkg;
  typedef enum logic [2:0] {
    MD_IDLE,
    MD_HEAD,
    MD_READ,
    MD_WRITE,
    MD_SKIP
  } mdio_state_t;

  typedef logic [15:0] reg_word_t;
endpackage : pcs_autoneg_mgmt_pkg
`default_nettype wire

// ===== common/loop_ctl_if.sv
// Loopback control passed from the register block to the idle stream generator.
`default_nettype none
interface loop_ctl_if;
  logic loopActive;
  logic loopInXcvr;

  modport ctl (output loopActive, output loopInXcvr);
  modport gen (input loopActive, input loopInXcvr);
endinterface : loop_ctl_if
`default_nettype wire

// ===== hw/pin_sync.sv
// Three-stage synchroniser whose output follows once the second and third stages agree.
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] dout_nxt;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        dout_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : dout[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else if (clkEn) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= dout_nxt;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ===== hw/idle_tx_gen.sv
// Transmit path that replaces data with Idle ordered sets while loopback is on.
`include "pcs_autoneg_mgmt_regs.svh"
`default_nettype none
module idle_tx_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  loop_ctl_if.gen loop,
  input wire logic [7:0] txDataIn,
  input wire logic txIsKIn,
  output logic [7:0] txData,
  output logic txIsK,
  output logic [7:0] rxLoopData,
  output logic rxLoopIsK,
  output logic xcvrLoopback
);
  logic phase_r;
  logic phase_nxt;
  logic [7:0] txData_nxt;
  logic txIsK_nxt;
  logic [7:0] rxLoopData_nxt;
  logic rxLoopIsK_nxt;
  logic xcvrLoopback_nxt;

  // Each Idle is K28.5 followed by D16.2; the pair restarts with K28.5 on entry.
  always_comb begin
    phase_nxt = loop.loopActive ? ~phase_r : 1'b0;
    txData_nxt = txDataIn;
    txIsK_nxt = txIsKIn;
    if (loop.loopActive) begin
      txData_nxt = phase_r ? `CODE_D16_2 : `CODE_K28_5; // RULE_14
      txIsK_nxt = ~phase_r; // RULE_14
    end
    rxLoopData_nxt = (loop.loopActive && !loop.loopInXcvr) ? txDataIn : 8'h00; // RULE_12
    rxLoopIsK_nxt = loop.loopActive && !loop.loopInXcvr && txIsKIn;
    xcvrLoopback_nxt = loop.loopActive && loop.loopInXcvr; // RULE_12
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 1'b0;
      txData <= 8'h00;
      txIsK <= 1'b0;
      rxLoopData <= 8'h00;
      rxLoopIsK <= 1'b0;
      xcvrLoopback <= 1'b0;
    end else if (clkEn) begin
      phase_r <= phase_nxt;
      txData <= txData_nxt;
      txIsK <= txIsK_nxt;
      rxLoopData <= rxLoopData_nxt;
      rxLoopIsK <= rxLoopIsK_nxt;
      xcvrLoopback <= xcvrLoopback_nxt;
    end
  end
endmodule : idle_tx_gen
`default_nettype wire

// ===== bench/pcs_autoneg_mgmt_regs_chk.sv
// Port assertions for the management register block.
`default_nettype none
module pcs_autoneg_mgmt_regs_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic sgmiiMode,
  input wire logic anComplete,
  input wire logic loopbackEn,
  input wire logic loopbackPosition,
  input wire logic anIntrStatus,
  input wire logic mdioOeN,
  input wire logic [7:0] txDataIn,
  input wire logic txIsKIn,
  input wire logic [7:0] txData,
  input wire logic txIsK,
  input wire logic [7:0] rxLoopData,
  input wire logic rxLoopIsK,
  input wire logic xcvrLoopback
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_idle_k;
    txIsK && txData == 8'hbc;
  endsequence
  sequence s_idle_d;
    !txIsK && txData == 8'h50;
  endsequence
  a_idle_start: assert property ($rose(loopbackEn) |=> s_idle_k)
    else $error("idle stream start wrong");
  a_idle_k_d: assert property ((loopbackEn && $past(loopbackEn)) ##0 s_idle_k |=> s_idle_d)
    else $error("idle data group missing");
  a_idle_d_k: assert property ((loopbackEn && $past(loopbackEn)) ##0 s_idle_d |=> s_idle_k)
    else $error("idle comma missing");
  a_xcvr_loop: assert property ($changed(xcvrLoopback) |->
    xcvrLoopback == $past(loopbackEn && loopbackPosition))
    else $error("transceiver loop wrong");
  a_rx_loop: assert property (loopbackEn && !loopbackPosition |=>
    rxLoopData == $past(txDataIn) && rxLoopIsK == $past(txIsKIn))
    else $error("pcs loopback data wrong");
  a_rx_quiet: assert property (!loopbackEn |=> rxLoopData == 8'h00 && !rxLoopIsK)
    else $error("loopback data without loopback");
  a_stat_cause: assert property ($rose(anIntrStatus) |-> $past(anComplete))
    else $error("status set without completion");
  // A write lands six clock cycles after the management clock pin rise that samples its last bit.
  a_stat_hold: assert property ($fell(anIntrStatus) |->
    $past(mdc, 6) && !$past(mdc, 7))
    else $error("status cleared outside a write");
  a_pos_write: assert property ($changed(loopbackPosition) |->
    $past(mdc, 6) && !$past(mdc, 7))
    else $error("position changed outside a write");
  a_md_quiet: assert property (!sgmiiMode |-> mdioOeN)
    else $error("drive while serial mode off");
  a_reset_out: assert property ($fell(rst) |-> mdioOeN && !anIntrStatus &&
    !loopbackPosition && !xcvrLoopback)
    else $error("reset values wrong");
endmodule : pcs_autoneg_mgmt_regs_chk

bind pcs_autoneg_mgmt_regs pcs_autoneg_mgmt_regs_chk u_chk (.clk(clk), .rst(rst), .mdc(mdc),
  .sgmiiMode(sgmiiMode), .anComplete(anComplete), .loopbackEn(loopbackEn),
  .loopbackPosition(loopbackPosition), .anIntrStatus(anIntrStatus), .mdioOeN(mdioOeN),
  .txDataIn(txDataIn), .txIsKIn(txIsKIn), .txData(txData), .txIsK(txIsK),
  .rxLoopData(rxLoopData), .rxLoopIsK(rxLoopIsK), .xcvrLoopback(xcvrLoopback));
`default_nettype wire

// ===== bench/mdio_station.sv
// Management station that runs MDIO read and write frames.
`default_nettype none
module mdio_station (
  input wire logic clk,
  input wire logic line,
  output logic mdc,
  output logic drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
  end
  // Each clock level holds 8 cycles; read bits are taken just before the next rise.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [33:0] f;
    f = {4'hd, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int k = 0; k < 34; k++) begin
      drv <= (op == 2'h2 && k > 15) ? 1'b1 : f[33 - k];
      repeat (8) @(posedge clk);
      if (k > 17) rd = {rd[14:0], line};
      mdc <= 1'b1;
      repeat (8) @(posedge clk);
      mdc <= 1'b0;
    end
    drv <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : mdio_station
`default_nettype wire

// ===== bench/pcs_autoneg_mgmt_regs_bench.sv
// Self-checking bench for the management register block.
`default_nettype none
module pcs_autoneg_mgmt_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] PHY = 5'h03;
  logic clk = 1'b0, rst = 1'b1, sgmiiMode = 1'b1, pageRxValid = 1'b0, anComplete = 1'b0;
  logic loopbackEn = 1'b0, mdc, drv, mdioOut, mdioOeN, line, txIsK, rxLoopIsK;
  logic clkEn = 1'b1;
  logic loopbackPosition, anIntrStatus, xcvrLoopback;
  logic [4:0] pg = 5'h00;
  logic [10:0] code = 11'h000;
  logic [7:0] txDataIn = 8'h00, txData, rxLoopData;
  logic [15:0] v;
  int n_errors = 0, num_checks = 0;
  always #4 clk = ~clk;
  always @(posedge clk) txDataIn <= txDataIn + 8'h01;
  assign line = mdioOeN ? drv : mdioOut;
  pcs_autoneg_mgmt_regs u_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .mdc(mdc), .mdioIn(line),
    .mdioOut(mdioOut), .mdioOeN(mdioOeN), .phyAddr(PHY), .sgmiiMode(sgmiiMode),
    .pageRxValid(pageRxValid), .pageRxNext(pg[4]), .pageRxAck(pg[3]), .pageRxMsg(pg[2]),
    .pageRxAck2(pg[1]), .pageRxToggle(pg[0]), .pageRxCode(code), .anComplete(anComplete),
    .loopbackEn(loopbackEn), .loopbackPosition(loopbackPosition), .anIntrStatus(anIntrStatus),
    .txDataIn(txDataIn), .txIsKIn(txDataIn[0]), .txData(txData), .txIsK(txIsK),
    .rxLoopData(rxLoopData), .rxLoopIsK(rxLoopIsK), .xcvrLoopback(xcvrLoopback));
  mdio_station u_sta (.clk(clk), .line(line), .mdc(mdc), .drv(drv));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
    u_sta.frame(2'h2, PHY, ra, 16'h0000, v);
    cmp(v, exp);
  endtask : rchk
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    u_sta.frame(2'h1, PHY, ra, d, v);
  endtask : wr
  task automatic an_pulse;
    @(posedge clk);
    anComplete <= 1'b1;
    @(posedge clk);
    anComplete <= 1'b0;
    @(posedge clk);
  endtask : an_pulse
  task automatic t_reset;
    rchk(5'h08, 16'h0000);
    rchk(5'h0f, 16'h8000);
    rchk(5'h10, 16'h0001);
    rchk(5'h11, 16'h0000);
    wr(5'h0f, 16'h7fff);
    wr(5'h08, 16'hffff);
    rchk(5'h0f, 16'h8000);
    rchk(5'h08, 16'h0000);
    rchk(5'h1f, 16'h0000);
  endtask : t_reset
  task automatic t_page(input logic [4:0] f, input logic [10:0] c);
    @(posedge clk);
    pg <= f;
    code <= c;
    pageRxValid <= 1'b1;
    @(posedge clk);
    pageRxValid <= 1'b0;
    pg <= ~f;
    code <= ~c;
    rchk(5'h08, {f, c});
  endtask : t_page
  task automatic t_intr;
    an_pulse;
    cmp({15'h0000, anIntrStatus}, 16'h0001);
    rchk(5'h10, 16'h0003);
    rchk(5'h10, 16'h0003);
    wr(5'h10, 16'hfffd);
    rchk(5'h10, 16'h0001);
    an_pulse;
    wr(5'h10, 16'h0002);
    rchk(5'h10, 16'h0000);
    an_pulse;
    rchk(5'h10, 16'h0000);
    wr(5'h10, 16'h0001);
    rchk(5'h10, 16'h0001);
  endtask : t_intr
  task automatic t_loop;
    wr(5'h11, 16'hffff);
    rchk(5'h11, 16'h0001);
    cmp({15'h0000, loopbackPosition}, 16'h0001);
    cmp({15'h0000, xcvrLoopback}, 16'h0000);
    @(negedge clk);
    cmp({7'h00, txIsK, txData}, {7'h00, ~txDataIn[0], txDataIn - 8'h01});
    @(posedge clk);
    loopbackEn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    cmp({7'h00, txIsK, txData}, 16'h01bc);
    cmp({15'h0000, xcvrLoopback}, 16'h0001);
    @(negedge clk);
    cmp({7'h00, txIsK, txData}, 16'h0050);
    wr(5'h11, 16'h0000);
    @(negedge clk);
    cmp({7'h00, rxLoopIsK, rxLoopData}, {7'h00, ~txDataIn[0], txDataIn - 8'h01});
    @(posedge clk);
    loopbackEn <= 1'b0;
  endtask : t_loop
  task automatic t_refuse;
    u_sta.frame(2'h2, PHY ^ 5'h01, 5'h10, 16'h0000, v);
    cmp(v, 16'hffff);
    @(posedge clk);
    sgmiiMode <= 1'b0;
    rchk(5'h10, 16'hffff);
    @(posedge clk);
    sgmiiMode <= 1'b1;
    rchk(5'h10, 16'h0001);
  endtask : t_refuse
  // A completion while the clock enable is low is lost; a mid-run reset restores defaults.
  task automatic t_hold;
    @(posedge clk);
    clkEn <= 1'b0;
    an_pulse;
    clkEn <= 1'b1;
    repeat (2) @(posedge clk);
    cmp({15'h0000, anIntrStatus}, 16'h0000);
    wr(5'h11, 16'h0001);
    wr(5'h10, 16'h0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(5'h10, 16'h0001);
    rchk(5'h11, 16'h0000);
  endtask : t_hold
  task automatic close_out;
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset;
    t_page(5'h1d, 11'h5a3);
    t_page(5'h0a, 11'h7ff);
    t_intr;
    t_loop;
    t_refuse;
    t_hold;
    close_out;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule : pcs_autoneg_mgmt_regs_bench
`default_nettype wire
